/* File: testbench/bdwc_port_model.sv */
// byte or word port on the system data bus
module bdwc_port_model (
   input  wire         core_clk,
   input  wire         drive,
   input  wire  [15:0] rd_data,
   output logic [15:0] sys_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last = 16'h0000;
   // a released bus shows the inverse, so a stale value never matches
   always @(posedge core_clk) if (drive) last <= rd_data;
   assign sys_data_in = drive ? rd_data : ~last;
endmodule // bdwc_port_model

/* File: testbench/bdwc_properties.sv */
// port checks for the bus driver width converter
module bdwc_properties #(parameter REF_CYCLES = 8) (
   input wire        core_clk, rst_b, dma_mode_indication, refresh_addr_out_req,
   input wire        refresh_addr_lsb_clk, first_byte_read_en_b, cross_lane_en_b,
   input wire        cpu_write, page_addr_bit16, refresh_due,
   input wire [2:0]  cpu_addr_hi, dma_page_hi,
   input wire [7:0]  cpu_addr_mid,
   input wire [15:0] cpu_data_bus_in, sys_data_in, cpu_data_bus_out, sys_data_out,
   input wire [1:0]  cpu_data_bus_oe,
   input wire [19:0] sys_addr_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire cpu_m = !dma_mode_indication;
   logic [15:0] since_due = 16'h0000;
   always @(posedge core_clk or negedge rst_b)
      if (!rst_b) since_due <= 16'h0000;
      else since_due <= refresh_due ? 16'h0001 : since_due + 16'h0001;
   a_ref_lsb_out: assert property (refresh_addr_out_req
      |=> sys_addr_bus[0] == $past(refresh_addr_lsb_clk)) else $error("refresh lsb");
   a_cpu_hi_addr: assert property (cpu_m
      |=> sys_addr_bus[19:17] == $past(cpu_addr_hi)) else $error("cpu hi addr");
   a_dma_hi_addr: assert property (!cpu_m
      |=> sys_addr_bus[19:16] == {$past(dma_page_hi), $past(page_addr_bit16)})
      else $error("dma page");
   a_cpu_mid_addr: assert property (cpu_m
      |=> sys_addr_bus[16:9] == $past(cpu_addr_mid)) else $error("cpu mid addr");
   a_conv_rd_word: assert property (cpu_m && !cpu_write && !cross_lane_en_b
      && !first_byte_read_en_b |=> cpu_data_bus_out[15:8] == $past(sys_data_in[7:0])
      && cpu_data_bus_oe == 2'h3) else $error("second read byte");
   a_wr_no_buffer: assert property (cpu_m && cpu_write
      |=> !cpu_data_bus_oe[0]) else $error("buffer drives on write");
   a_conv_wr_cross: assert property (cpu_m && cpu_write && !cross_lane_en_b
      |=> sys_data_out[7:0] == $past(cpu_data_bus_in[15:8])) else $error("write cross");
   a_ref_spacing: assert property (refresh_due == (since_due == REF_CYCLES))
      else $error("refresh spacing");
endmodule // bdwc_properties
bind bdwc_top bdwc_properties #(.REF_CYCLES(REF_CYCLES)) chk_u (.*);

/* File: testbench/bdwc_top_tb.sv */
// self-checking bench for the bus driver width converter
module bdwc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst_b = 0, dma_mode_indication = 0, refresh_addr_out_req = 0;
   logic refresh_addr_lsb_clk = 0, slave_dma_addr_strobe = 0, master_dma_addr_strobe = 0;
   logic convert_dummy_addr = 0, first_byte_read_en_b = 1, hi_lane_en = 0, lo_lane_en = 0;
   logic cross_lane_en_b = 1, cross_dir_hi_to_lo = 0, cpu_write = 0, page_addr_bit16 = 0;
   logic        drive = 0, aux_addr_bit8, refresh_due;
   logic [2:0]  cpu_addr_hi = 0, dma_page_hi = 0;
   logic [7:0]  cpu_addr_mid = 0, aux_data_byte = 0;
   logic [15:0] cpu_data_bus_in = 0, rd_data = 0, cpu_data_bus_out, sys_data_in, sys_data_out;
   logic [1:0]  cpu_data_bus_oe, sys_data_oe;
   logic [19:0] sys_addr_bus;
   int          errors = 0, compares = 0, cycles = 0;
   bdwc_top #(.REF_CYCLES(8)) dut_u (.*);
   bdwc_port_model port_u (.*);
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (++cycles == 4000) begin
      errors++;
      print_verdict();
   end
   task automatic step(int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(logic [19:0] got, logic [19:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_word();
      {hi_lane_en, lo_lane_en, cpu_write, cpu_data_bus_in} = {3'h7, 16'h1234};
      step();
      chk({sys_data_oe, sys_data_out}, {2'h3, 16'h1234});
      {cpu_write, drive, rd_data} = {2'h1, 16'hBEEF};
      step();
      chk(cpu_data_bus_out, 16'hBEEF);
      {hi_lane_en, drive} = 2'h0;
   endtask
   task automatic t_conv_rd();
      {convert_dummy_addr, drive, rd_data} = {2'h3, 16'h00A5};
      step();
      {convert_dummy_addr, cross_lane_en_b, first_byte_read_en_b, rd_data} = 19'h003C;
      step();
      chk({cpu_data_bus_oe, cpu_data_bus_out}, {2'h3, 16'h3CA5});
      {cross_lane_en_b, first_byte_read_en_b, drive} = 3'h6;
   endtask
   task automatic t_conv_wr();
      {cpu_write, cpu_data_bus_in} = {1'h1, 16'h5AC3};
      step();
      chk(sys_data_out[7:0], 8'hC3);
      cross_lane_en_b = 0;
      step();
      chk({cpu_data_bus_oe[0], sys_data_out[7:0]}, 9'h05A);
      {lo_lane_en, cpu_write, cross_lane_en_b, cpu_addr_mid} = {3'h1, 8'h96};
      step();
      chk(sys_addr_bus[16:9], 8'h96);
   endtask
   task automatic t_dma();
      {dma_mode_indication, dma_page_hi, page_addr_bit16} = 5'h1D;
      {slave_dma_addr_strobe, cpu_data_bus_in} = {1'h1, 16'h00C7};
      step();
      slave_dma_addr_strobe = 0;
      step();
      chk({sys_addr_bus[19:9], aux_addr_bit8}, 12'hDC7);
      {master_dma_addr_strobe, cpu_data_bus_in} = {1'h1, 16'h0038};
      step();
      master_dma_addr_strobe = 0;
      step();
      chk({sys_addr_bus[19:9], aux_addr_bit8}, 12'hD38);
      {hi_lane_en, lo_lane_en} = 2'h3;
      step();
      chk({cpu_data_bus_oe, sys_data_oe}, 4'h0);
      {hi_lane_en, lo_lane_en} = 2'h0;
      {cross_lane_en_b, drive, rd_data} = {2'h1, 16'h0069};
      step();
      chk(sys_data_out[15:8], 8'h69);
      {cross_dir_hi_to_lo, rd_data} = {1'h1, 16'h4200};
      step();
      chk(sys_data_out[7:0], 8'h42);
      {dma_mode_indication, cross_lane_en_b, drive} = 3'h2;
   endtask
   task automatic t_refresh(int n, logic [8:0] exp);
      refresh_addr_out_req = 1;
      repeat (n) begin
         refresh_addr_lsb_clk = 1;
         step(2);
         refresh_addr_lsb_clk = 0;
         step(2);
      end
      chk(sys_addr_bus[8:0], exp);
   endtask
   initial begin
      step(5);
      rst_b = 1;
      step();
      t_word();
      t_conv_rd();
      t_conv_wr();
      t_dma();
      t_refresh(3, 9'h002);
      t_refresh(509, 9'h000);
      print_verdict();
   end
endmodule // bdwc_top_tb

/* File: verilog/bdwc_map.vh */
// constants for the bus driver width converter
`ifndef BDWC_MAP_VH
`define BDWC_MAP_VH
`define BDWC_REF_BITS       9
`define BDWC_REF_RESET      9'h000
`define BDWC_REF_INTERVAL_NS 15000
`define BDWC_CLK_PERIOD_NS  10
`define BDWC_REF_CYCLES     (`BDWC_REF_INTERVAL_NS / `BDWC_CLK_PERIOD_NS)
`define BDWC_CONV_SYS_CYCLES 12
`define BDWC_WORD_CPU_CYCLES 3
`define BDWC_LANE_W         8
`define BDWC_LANE_RESET     8'h00
`endif

/* File: verilog/bdwc_top.v */
// bus driver: lane steering, 16/8 conversion, system address multiplexing
`include "bdwc_map.vh"

// ****************************************************************
// rule summary
// ****************************************************************
// How it works
// - refresh output request puts refresh counter on system address.
// - slave dma strobe latches dma address byte from data bus.
// - master dma strobe, active high, latches and holds dma address.
// - cpu data is 16 bits: high lane 15..8, low lane 7..0.
// - word port: lanes pass straight, no conversion.
// - word access without waits finishes in three cpu cycles.
// - converted read stores first even byte from low system lane.
// - second byte goes low system to high cpu; buffer drives low cpu.
// - second read byte disables direct low lane path.
// - converted write first sends cpu low byte on direct path.
// - converted write second byte crosses cpu high to system low.
// - buffer never drives on writes; second write byte blocks direct path.
// - full word to byte conversion takes twelve system clocks.
// - byte dma to odd memory crosses lanes either direction.
// - word dma leaves all steering paths inactive.
// - address 19..17 from cpu in cpu mode, dma page in dma mode.
// - address 16..9 cpu in cpu mode; dma gives page16 and latched byte bits 7..1.
// - address 8..0 carries refresh counter, refreshed every 15 us.
// - mode low is cpu, high is dma; selects sources.
// - refresh lsb input appears as address 0 and clocks counter.
// - dummy address input high stores first read byte.
// - first byte read enable low in second read outputs buffer.
module bdwc_top #(
   parameter REF_CYCLES = `BDWC_REF_CYCLES
) (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        dma_mode_indication,
   input  wire        refresh_addr_out_req,
   input  wire        refresh_addr_lsb_clk,
   input  wire        slave_dma_addr_strobe,
   input  wire        master_dma_addr_strobe,
   input  wire        convert_dummy_addr,
   input  wire        first_byte_read_en_b,
   input  wire        hi_lane_en,
   input  wire        lo_lane_en,
   input  wire        cross_lane_en_b,
   input  wire        cross_dir_hi_to_lo,
   input  wire        cpu_write,
   input  wire [2:0]  cpu_addr_hi,
   input  wire [2:0]  dma_page_hi,
   input  wire [7:0]  cpu_addr_mid,
   input  wire        page_addr_bit16,
   input  wire [7:0]  aux_data_byte,
   input  wire [15:0] cpu_data_bus_in,
   output reg  [15:0] cpu_data_bus_out,
   output reg  [1:0]  cpu_data_bus_oe,
   input  wire [15:0] sys_data_in,
   output reg  [15:0] sys_data_out,
   output reg  [1:0]  sys_data_oe,
   output reg  [19:0] sys_addr_bus,
   output reg         aux_addr_bit8,
   output reg         refresh_due
);

   // ****************************************************************
   // registers
   // ****************************************************************
   reg  [`BDWC_REF_BITS-1:0] ref_cnt;
   reg                       ref_clk_d;
   reg  [7:0]                dma_addr_lat;
   reg  [7:0]                first_byte;
   reg  [15:0]               ref_tmr;
   reg  [15:0]               next_cpu_data;
   reg  [1:0]                next_cpu_oe;
   reg  [15:0]               next_sys_data;
   reg  [1:0]                next_sys_oe;
   reg  [2:0]                next_addr_hi;
   reg  [7:0]                next_addr_mid;
   reg  [8:0]                next_addr_lo;
   reg                       next_aux8;

   // ****************************************************************
   // path decode
   // ****************************************************************
   // second byte of a cpu-mode conversion in the asked direction
   function second_byte;
      input cross_en_b;
      input dma_mode;
      input write;
      input want_write;
      begin
         second_byte = ~cross_en_b & ~dma_mode & (write == want_write);
      end
   endfunction

   wire ref_tick  = refresh_addr_lsb_clk & ~ref_clk_d;
   wire cross_on  = ~cross_lane_en_b;
   wire second_rd = second_byte(cross_lane_en_b, dma_mode_indication, cpu_write, 1'b0);
   wire second_wr = second_byte(cross_lane_en_b, dma_mode_indication, cpu_write, 1'b1);
   wire tmr_wrap  = (ref_tmr == REF_CYCLES - 1);

   // ****************************************************************
   // refresh counter
   // ****************************************************************
   // idle level of the lsb input is low, so no false edge after reset
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_clk_d <= 1'b0;
      end else begin
         ref_clk_d <= refresh_addr_lsb_clk;
      end
   end

   // nine bits, wraps to zero on its own overflow
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_cnt <= `BDWC_REF_RESET;
      end else if (ref_tick) begin
         ref_cnt <= ref_cnt + 9'h001;
      end
   end

   // ****************************************************************
   // dma address latch
   // ****************************************************************
   // either strobe catches the byte; master one is active high
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_addr_lat <= `BDWC_LANE_RESET;
      end else if (slave_dma_addr_strobe | master_dma_addr_strobe) begin
         dma_addr_lat <= cpu_data_bus_in[7:0];
      end
   end

   // ****************************************************************
   // first byte buffer
   // ****************************************************************
   // only a cpu-mode read may load it, so writes and dma never disturb it
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         first_byte <= `BDWC_LANE_RESET;
      end else if (convert_dummy_addr && !cpu_write && !dma_mode_indication) begin
         first_byte <= sys_data_in[7:0];
      end
   end

   // ****************************************************************
   // refresh interval marker
   // ****************************************************************
   // free-running, so the spacing holds whatever the bus is doing
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_tmr <= 16'h0000;
      end else if (tmr_wrap) begin
         ref_tmr <= 16'h0000;
      end else begin
         ref_tmr <= ref_tmr + 16'h0001;
      end
   end

   // one-cycle pulse for the refresh controller next door
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_due <= 1'b0;
      end else begin
         refresh_due <= tmr_wrap;
      end
   end

   // ****************************************************************
   // data steering
   // ****************************************************************
   always @* begin
      next_cpu_data = 16'h0000;
      next_cpu_oe   = 2'b00;
      next_sys_data = 16'h0000;
      next_sys_oe   = 2'b00;
      if (dma_mode_indication) begin
         // byte dma to odd memory only; word dma leaves paths idle
         if (cross_on) begin
            if (cross_dir_hi_to_lo) begin
               next_sys_data[7:0] = sys_data_in[15:8];
               next_sys_oe[0]     = 1'b1;
            end else begin
               next_sys_data[15:8] = sys_data_in[7:0];
               next_sys_oe[1]      = 1'b1;
            end
         end
      end else if (cpu_write) begin
         if (second_wr) begin
            next_sys_data[7:0] = cpu_data_bus_in[15:8];
            next_sys_oe[0]     = 1'b1;
         end else begin
            if (lo_lane_en) begin
               next_sys_data[7:0] = cpu_data_bus_in[7:0];
               next_sys_oe[0]     = 1'b1;
            end
            if (hi_lane_en) begin
               next_sys_data[15:8] = cpu_data_bus_in[15:8];
               next_sys_oe[1]      = 1'b1;
            end
         end
      end else begin
         if (second_rd) begin
            next_cpu_data[15:8] = sys_data_in[7:0];
            next_cpu_oe[1]      = 1'b1;
            if (!first_byte_read_en_b) begin
               next_cpu_data[7:0] = first_byte;
               next_cpu_oe[0]     = 1'b1;
            end
         end else begin
            if (lo_lane_en) begin
               next_cpu_data[7:0] = sys_data_in[7:0];
               next_cpu_oe[0]     = 1'b1;
            end
            if (hi_lane_en) begin
               next_cpu_data[15:8] = sys_data_in[15:8];
               next_cpu_oe[1]      = 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // address bits 19..17
   // ****************************************************************
   // the mode picks one source, so the two never fight on the bus
   always @* begin
      if (dma_mode_indication) begin
         next_addr_hi = dma_page_hi;
      end else begin
         next_addr_hi = cpu_addr_hi;
      end
   end

   // ****************************************************************
   // address bits 16..9 and auxiliary bit 8
   // ****************************************************************
   // dma form is page bit 16 over the latched byte, its lsb on the aux pin
   always @* begin
      if (dma_mode_indication) begin
         next_addr_mid = {page_addr_bit16, dma_addr_lat[7:1]};
         next_aux8     = dma_addr_lat[0];
      end else begin
         next_addr_mid = cpu_addr_mid;
         next_aux8     = 1'b0;
      end
   end

   // ****************************************************************
   // address bits 8..0
   // ****************************************************************
   // counter bit 0 is replaced by the lsb input itself
   always @* begin
      if (refresh_addr_out_req) begin
         next_addr_lo = {ref_cnt[8:1], refresh_addr_lsb_clk};
      end else begin
         next_addr_lo = 9'h000;
      end
   end

   // ****************************************************************
   // registered cpu side outputs
   // ****************************************************************
   // cycle counts per access are paced by the neighbours' enables
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_data_bus_out <= 16'h0000;
         cpu_data_bus_oe  <= 2'b00;
      end else begin
         cpu_data_bus_out <= next_cpu_data;
         cpu_data_bus_oe  <= next_cpu_oe;
      end
   end

   // ****************************************************************
   // registered system side outputs
   // ****************************************************************
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_data_out <= 16'h0000;
         sys_data_oe  <= 2'b00;
      end else begin
         sys_data_out <= next_sys_data;
         sys_data_oe  <= next_sys_oe;
      end
   end

   // ****************************************************************
   // registered address outputs
   // ****************************************************************
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_addr_bus  <= 20'h00000;
         aux_addr_bit8 <= 1'b0;
      end else begin
         sys_addr_bus  <= {next_addr_hi, next_addr_mid, next_addr_lo};
         aux_addr_bit8 <= next_aux8;
      end
   end
endmodule // bdwc_top
